// ==== design/pfsw_ctrl.sv ====
// Program flash self-write controller: registers, unlock key, row erase and program.
// Assumes a flash macro that returns read data within the cycle of its read strobe, and a
// programmer front end and configuration store that run on the same clock.
`timescale 1ns/1ps

module pfsw_ctrl #(
  parameter int OP_CYCLES = pfsw_pkg::OP_CYCLES,
  parameter int FLASH_WORDS = pfsw_pkg::FLASH_WORDS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pwr_on_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic core_force_nop,
  output logic core_stall,
  input wire logic cfg_code_lock,
  input wire logic [1:0] cfg_self_update_guard,
  input wire logic ext_req,
  input wire logic [1:0] ext_cmd,
  input wire logic [14:0] ext_addr,
  input wire logic [13:0] ext_wdata,
  output logic ext_ack,
  output logic ext_denied,
  output logic [13:0] ext_rdata,
  output logic [14:0] flash_addr,
  output logic [13:0] flash_wdata,
  output logic flash_rd,
  output logic flash_wr,
  output logic flash_row_erase,
  output logic flash_bulk_erase,
  output logic flash_user_id,
  input wire logic [13:0] flash_rdata
);

  typedef struct packed {
    pfsw_pkg::pfsw_state_t state;
    logic ack;
    logic [31:0] dat;
    logic [7:0] data_lo;
    logic [5:0] data_hi;
    logic [7:0] ptr_lo;
    logic [6:0] ptr_hi;
    logic rd;
    logic wr;
    logic permit;
    logic aborted;
    logic erase_sel;
    logic latch_only;
    logic uid_sel;
    logic [1:0] key_stage;
    logic [31:0][13:0] latch;
    logic [4:0] idx;
    logic [31:0] timer;
    logic lock;
    logic [1:0] guard;
    logic stall;
    logic nop;
    logic [14:0] f_addr;
    logic [13:0] f_wdata;
    logic f_rd;
    logic f_wr;
    logic f_erase;
    logic f_bulk;
    logic ext_ack;
    logic ext_denied;
    logic [13:0] ext_rdata;
  } pfsw_regs_t;

  pfsw_regs_t s_r;
  pfsw_regs_t s_nxt;

  // Guarded region grows upward from word zero
  function automatic logic pfsw_guarded(input logic [14:0] a, input logic [1:0] g);
    logic hit;
    hit = 1'b0;
    unique case (g)
      pfsw_pkg::GUARD_ALL: hit = 1'b1;
      pfsw_pkg::GUARD_HALF: hit = (int'(a) < FLASH_WORDS / 2);
      pfsw_pkg::GUARD_QUARTER: hit = (int'(a) < FLASH_WORDS / 4);
      pfsw_pkg::GUARD_NONE: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [7:0] pfsw_ctl_byte(input pfsw_regs_t r);
    logic [7:0] b;
    b = 8'h00;
    b[pfsw_pkg::CTL_RD] = r.rd;
    b[pfsw_pkg::CTL_WR] = r.wr;
    b[pfsw_pkg::CTL_PERMIT] = r.permit;
    b[pfsw_pkg::CTL_ABORTED] = r.aborted;
    b[pfsw_pkg::CTL_ERASE] = r.erase_sel;
    b[pfsw_pkg::CTL_LATCH] = r.latch_only;
    b[pfsw_pkg::CTL_UID] = r.uid_sel;
    return b;
  endfunction

  function automatic logic [31:0] pfsw_read(input pfsw_regs_t r, input logic [7:0] adr);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (adr)
      pfsw_pkg::OFS_DATA_LO: d[7:0] = r.data_lo;
      pfsw_pkg::OFS_DATA_HI: d[5:0] = r.data_hi;
      pfsw_pkg::OFS_PTR_LO: d[7:0] = r.ptr_lo;
      pfsw_pkg::OFS_PTR_HI: d[6:0] = r.ptr_hi;
      pfsw_pkg::OFS_CTL: d[7:0] = pfsw_ctl_byte(r);
      pfsw_pkg::OFS_CFG: begin
        d[0] = r.lock;
        d[2:1] = r.guard;
        d[pfsw_pkg::CFG_BUSY] = (r.state != pfsw_pkg::PFSW_IDLE);
      end
      default: d = 32'h0000_0000; // Key port reads zero
    endcase
    return d;
  endfunction

  always_comb begin
    logic take;
    logic done;
    logic wr_en;
    logic [7:0] wbyte;
    logic [14:0] ptr;
    logic ctl_start;
    take = 1'b0;
    done = 1'b0;
    wr_en = 1'b0;
    wbyte = 8'h00;
    ptr = 15'h0000;
    ctl_start = 1'b0;
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.f_rd = 1'b0;
    s_nxt.f_wr = 1'b0;
    s_nxt.f_erase = 1'b0;
    s_nxt.f_bulk = 1'b0;
    s_nxt.ext_ack = 1'b0;
    s_nxt.ext_denied = 1'b0;

    take = wb_cyc_i & wb_stb_i & ~s_r.ack;
    done = wb_cyc_i & wb_stb_i & s_r.ack;
    wr_en = done & wb_we_i & wb_sel_i[0];
    wbyte = wb_dat_i[7:0];
    ptr = {s_r.ptr_hi, s_r.ptr_lo};
    ctl_start = wr_en && (wb_adr_i == pfsw_pkg::OFS_CTL)
      && (wbyte[pfsw_pkg::CTL_RD] || wbyte[pfsw_pkg::CTL_WR]);

    if (take) begin
      s_nxt.ack = 1'b1;
      s_nxt.dat = pfsw_read(s_r, wb_adr_i);
    end

    unique case (s_r.state)
      pfsw_pkg::PFSW_IDLE: begin
        // Programmer waits while software owns the flash port
        // A request still held in its answer cycle is not taken twice
        if (ext_req && !ctl_start && !s_r.ext_ack && !s_r.ext_denied) begin
          s_nxt.f_addr = ext_addr;
          s_nxt.f_wdata = ext_wdata;
          if (ext_cmd == pfsw_pkg::EXT_BULK) begin
            s_nxt.f_bulk = 1'b1;
            s_nxt.lock = 1'b1;
            s_nxt.guard = pfsw_pkg::GUARD_NONE;
            s_nxt.ext_ack = 1'b1;
          end else if (!s_r.lock || ext_cmd != pfsw_pkg::EXT_WRITE
                       && ext_cmd != pfsw_pkg::EXT_READ) begin
            s_nxt.ext_denied = 1'b1;
          end else if (ext_cmd == pfsw_pkg::EXT_WRITE) begin
            s_nxt.f_wr = 1'b1; // Guard does not apply here
            s_nxt.ext_ack = 1'b1;
          end else begin
            s_nxt.f_rd = 1'b1;
            s_nxt.ext_ack = 1'b1;
          end
        end
      end
      pfsw_pkg::PFSW_RD: begin
        s_nxt.data_lo = flash_rdata[7:0];
        s_nxt.data_hi = flash_rdata[13:8];
        s_nxt.rd = 1'b0;
        s_nxt.state = pfsw_pkg::PFSW_IDLE;
      end
      pfsw_pkg::PFSW_NOP1: s_nxt.state = pfsw_pkg::PFSW_NOP2;
      pfsw_pkg::PFSW_NOP2: begin
        if (s_r.latch_only) begin
          s_nxt.wr = 1'b0;
          s_nxt.state = pfsw_pkg::PFSW_IDLE;
        end else if (s_r.erase_sel) begin
          s_nxt.f_erase = 1'b1;
          s_nxt.f_addr = {ptr[14:pfsw_pkg::ROW_BITS], 5'h00};
          s_nxt.timer = 32'(OP_CYCLES - 1);
          s_nxt.state = pfsw_pkg::PFSW_WAIT;
        end else begin
          s_nxt.idx = 5'h00;
          s_nxt.state = pfsw_pkg::PFSW_PROG;
        end
      end
      pfsw_pkg::PFSW_PROG: begin
        // Erased latches program nothing, so partial rows need no erase
        s_nxt.f_wr = 1'b1;
        s_nxt.f_addr = {ptr[14:pfsw_pkg::ROW_BITS], s_r.idx};
        s_nxt.f_wdata = s_r.latch[s_r.idx];
        s_nxt.idx = s_r.idx + 5'h01;
        if (s_r.idx == 5'(pfsw_pkg::ROW_WORDS - 1)) begin
          s_nxt.timer = 32'(OP_CYCLES - 1);
          s_nxt.state = pfsw_pkg::PFSW_WAIT;
        end
      end
      pfsw_pkg::PFSW_WAIT: begin
        if (s_r.timer == 32'h0000_0000) begin
          s_nxt.wr = 1'b0;
          s_nxt.state = pfsw_pkg::PFSW_IDLE;
          if (!s_r.erase_sel) begin
            for (int i = 0; i < pfsw_pkg::ROW_WORDS; i++) begin
              s_nxt.latch[i] = pfsw_pkg::ERASED_WORD;
            end
          end
        end else begin
          s_nxt.timer = s_r.timer - 32'h0000_0001;
        end
      end
      default: s_nxt.state = pfsw_pkg::PFSW_IDLE;
    endcase

    // Programmer read data returns the cycle after its strobe
    if (s_r.f_rd && s_r.state == pfsw_pkg::PFSW_IDLE) begin
      s_nxt.ext_rdata = flash_rdata;
    end

    // Any completed access breaks a partial key
    if (done) begin
      s_nxt.key_stage = pfsw_pkg::KEY_NONE;
    end

    if (wr_en) begin
      unique case (wb_adr_i)
        pfsw_pkg::OFS_DATA_LO: s_nxt.data_lo = wbyte;
        pfsw_pkg::OFS_DATA_HI: s_nxt.data_hi = wbyte[5:0];
        pfsw_pkg::OFS_PTR_LO: s_nxt.ptr_lo = wbyte;
        pfsw_pkg::OFS_PTR_HI: s_nxt.ptr_hi = wbyte[6:0];
        pfsw_pkg::OFS_KEY: begin
          if (s_r.key_stage == pfsw_pkg::KEY_NONE && wbyte == pfsw_pkg::KEY_FIRST) begin
            s_nxt.key_stage = pfsw_pkg::KEY_HALF;
          end else if (s_r.key_stage == pfsw_pkg::KEY_HALF
                       && wbyte == pfsw_pkg::KEY_SECOND) begin
            s_nxt.key_stage = pfsw_pkg::KEY_FULL;
          end
        end
        pfsw_pkg::OFS_CTL: begin
          s_nxt.permit = wbyte[pfsw_pkg::CTL_PERMIT];
          s_nxt.aborted = wbyte[pfsw_pkg::CTL_ABORTED];
          // Mode bits frozen while an operation uses them
          if (s_r.state == pfsw_pkg::PFSW_IDLE) begin
            s_nxt.erase_sel = wbyte[pfsw_pkg::CTL_ERASE];
            s_nxt.latch_only = wbyte[pfsw_pkg::CTL_LATCH];
            s_nxt.uid_sel = wbyte[pfsw_pkg::CTL_UID];
          end
          // Zeros leave both start bits alone
          if (wbyte[pfsw_pkg::CTL_WR] && s_r.key_stage == pfsw_pkg::KEY_FULL
              && s_r.permit && s_r.state == pfsw_pkg::PFSW_IDLE
              && !pfsw_guarded(ptr, s_r.guard)) begin
            s_nxt.wr = 1'b1;
            s_nxt.state = pfsw_pkg::PFSW_NOP1;
            if (!wbyte[pfsw_pkg::CTL_ERASE]) begin
              s_nxt.latch[s_r.ptr_lo[4:0]] = {s_r.data_hi, s_r.data_lo};
            end
          end else if (wbyte[pfsw_pkg::CTL_RD] && s_r.state == pfsw_pkg::PFSW_IDLE) begin
            s_nxt.rd = 1'b1;
            s_nxt.f_rd = 1'b1;
            s_nxt.f_addr = ptr;
            s_nxt.state = pfsw_pkg::PFSW_RD;
          end
        end
        default: s_nxt.key_stage = s_nxt.key_stage;
      endcase
    end

    s_nxt.nop = (s_nxt.state == pfsw_pkg::PFSW_NOP1) || (s_nxt.state == pfsw_pkg::PFSW_NOP2);
    s_nxt.stall = (s_nxt.state == pfsw_pkg::PFSW_PROG)
      || (s_nxt.state == pfsw_pkg::PFSW_WAIT);

    if (sys_rst || pwr_on_rst) begin
      s_nxt = '0;
      s_nxt.state = pfsw_pkg::PFSW_IDLE;
      for (int i = 0; i < pfsw_pkg::ROW_WORDS; i++) begin
        s_nxt.latch[i] = pfsw_pkg::ERASED_WORD;
      end
      // Config store is reloaded on every reset
      s_nxt.lock = cfg_code_lock;
      s_nxt.guard = cfg_self_update_guard;
      // Flag survives a device reset; power-on or a software write of zero clears it
      s_nxt.aborted = !pwr_on_rst && (s_r.aborted || s_r.wr);
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign core_force_nop = s_r.nop;
  assign core_stall = s_r.stall;
  assign ext_ack = s_r.ext_ack;
  assign ext_denied = s_r.ext_denied;
  assign ext_rdata = s_r.ext_rdata;
  assign flash_addr = s_r.f_addr;
  assign flash_wdata = s_r.f_wdata;
  assign flash_rd = s_r.f_rd;
  assign flash_wr = s_r.f_wr;
  assign flash_row_erase = s_r.f_erase;
  assign flash_bulk_erase = s_r.f_bulk;
  assign flash_user_id = s_r.uid_sel;

endmodule

// ==== design/pfsw_pkg.sv ====
// Constants, register map and state codes of the program flash self-write controller.
// Assumes a 25 MHz system clock and a byte-wide register view on a 32-bit Wishbone bus.
// What this block does
// - Word data is read and written through a low and high byte pair, 14 bits.
// - The word address comes from a high and a low pointer byte, 15 bits.
// - Pointer pair spans 32K words; high byte upper address, low byte lower.
// - An internal timer, not software, sets each erase and program duration.
// - Cleared code lock blocks programmer reads and writes; self-updates still work.
// - Only a programmer bulk erase releases code lock, erasing memory, config, IDs.
// - Self-erase and self-write into the guarded region are refused; programmer unaffected.
// - Read-start and write-start ignore written zeros; hardware clears them on completion.
// - A write starts only with modify permit set; permit is clear after power-up.
// - A device reset that cuts a write short sets the aborted-update flag.
// - Unlock key port is write-only and reads back as zero.
// - A 32-word row is the smallest erasable region.
// - Row data sits in hidden 14-bit latches loaded one by one via data pair.
// - Unprogrammed words may be programmed without erasing the row first.
// - An accepted write-start forces two no-op instruction cycles.
// - Row erase or program stalls the core until done, about 2 ms.
// - A latch load inserts only the two no-ops and no stall.
package pfsw_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int OP_TIME_US = 2000;
  localparam int OP_CYCLES = OP_TIME_US * (CLK_HZ / 1_000_000);

  localparam int WORD_W = 14;
  localparam int ADDR_W = 15;
  localparam int ROW_BITS = 5;
  localparam int ROW_WORDS = 32;
  localparam int FLASH_WORDS = 32768;
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;

  localparam logic [7:0] OFS_DATA_LO = 8'h00;
  localparam logic [7:0] OFS_DATA_HI = 8'h04;
  localparam logic [7:0] OFS_PTR_LO = 8'h08;
  localparam logic [7:0] OFS_PTR_HI = 8'h0C;
  localparam logic [7:0] OFS_CTL = 8'h10;
  localparam logic [7:0] OFS_KEY = 8'h14;
  localparam logic [7:0] OFS_CFG = 8'h18;

  localparam int CTL_RD = 0;
  localparam int CTL_WR = 1;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_ABORTED = 3;
  localparam int CTL_ERASE = 4;
  localparam int CTL_LATCH = 5;
  localparam int CTL_UID = 6;
  localparam int CFG_BUSY = 7;

  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [1:0] KEY_NONE = 2'h0;
  localparam logic [1:0] KEY_HALF = 2'h1;
  localparam logic [1:0] KEY_FULL = 2'h2;

  localparam logic [1:0] GUARD_ALL = 2'h0;
  localparam logic [1:0] GUARD_HALF = 2'h1;
  localparam logic [1:0] GUARD_QUARTER = 2'h2;
  localparam logic [1:0] GUARD_NONE = 2'h3;

  localparam logic [1:0] EXT_READ = 2'h0;
  localparam logic [1:0] EXT_WRITE = 2'h1;
  localparam logic [1:0] EXT_BULK = 2'h2;

  typedef enum logic [5:0] {
    PFSW_IDLE = 6'b000001,
    PFSW_RD = 6'b000010,
    PFSW_NOP1 = 6'b000100,
    PFSW_NOP2 = 6'b001000,
    PFSW_PROG = 6'b010000,
    PFSW_WAIT = 6'b100000
  } pfsw_state_t;

endpackage

// ==== testbench/pfsw_ctrl_assertions.sv ====
// Concurrent checks on the flash self-write controller ports.
// Assumes the bench never overlaps operations and binds the same OP_CYCLES.
`timescale 1ns/1ps
module pfsw_ctrl_assertions #(
  parameter int OP_CYCLES = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pwr_on_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic core_force_nop,
  input wire logic core_stall,
  input wire logic ext_req,
  input wire logic ext_ack,
  input wire logic ext_denied,
  input wire logic flash_rd,
  input wire logic flash_row_erase
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || pwr_on_rst);
  // Program walk adds the 32 latch writes plus a few state cycles
  localparam int MAX_ST = OP_CYCLES + 64;
  logic [31:0] st_cnt_r, st_cnt_nxt;
  always_comb st_cnt_nxt = core_stall ? st_cnt_r + 32'h1 : 32'h0;
  always_ff @(posedge clk) begin
    if (sys_rst || pwr_on_rst) st_cnt_r <= 32'h0;
    else st_cnt_r <= st_cnt_nxt;
  end
  logic ctl_ack;
  assign ctl_ack = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == pfsw_pkg::OFS_CTL;

  property p_key_zero;
    wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == pfsw_pkg::OFS_KEY && !wb_ack_o
      |=> wb_dat_o == 32'h0;
  endproperty
  a_key_zero: assert property (p_key_zero) else $error("key port read not zero");
  property p_nop_two;
    $rose(core_force_nop) |=> core_force_nop ##1 !core_force_nop;
  endproperty
  a_nop_two: assert property (p_nop_two) else $error("forced no-op not two cycles");
  property p_nop_cause;
    $rose(core_force_nop) |-> $past(ctl_ack && wb_dat_i[1]);
  endproperty
  a_nop_cause: assert property (p_nop_cause) else $error("no-op without start");
  property p_erase_nop;
    flash_row_erase |-> $past(core_force_nop) && !core_force_nop && core_stall;
  endproperty
  a_erase_nop: assert property (p_erase_nop) else $error("erase not after no-ops");
  property p_stall_start;
    $rose(core_stall) |-> $past(core_force_nop);
  endproperty
  a_stall_start: assert property (p_stall_start) else $error("stall not after no-ops");
  property p_stall_len;
    $fell(core_stall) |-> st_cnt_r >= OP_CYCLES && st_cnt_r <= MAX_ST;
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  property p_rd_cause;
    ctl_ack && wb_dat_i[0] && !core_stall && !core_force_nop |=> flash_rd;
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read-start gave no read");
  property p_ext_answer;
    ext_req && !ext_ack && !ext_denied && !core_stall && !core_force_nop && !wb_cyc_i
      |=> ext_ack != ext_denied;
  endproperty
  a_ext_answer: assert property (p_ext_answer) else $error("programmer not answered");
endmodule

bind pfsw_ctrl pfsw_ctrl_assertions #(.OP_CYCLES(OP_CYCLES)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .pwr_on_rst(pwr_on_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .core_force_nop(core_force_nop), .core_stall(core_stall), .ext_req(ext_req),
  .ext_ack(ext_ack), .ext_denied(ext_denied), .flash_rd(flash_rd),
  .flash_row_erase(flash_row_erase)
);

// ==== testbench/tb.sv ====
// Self-checking bench for the flash self-write controller.
// Assumes a flash macro whose read data follows its address within the same cycle.
`timescale 1ns/1ps
module tb;
  localparam int OPC = 20;
  logic clk, sys_rst, pwr_on_rst, wb_cyc_i, wb_stb_i, wb_we_i, cfg_code_lock, ext_req, ok;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic wb_ack_o, core_force_nop, core_stall, ext_ack, ext_denied;
  logic flash_rd, flash_wr, flash_row_erase, flash_bulk_erase, flash_user_id;
  logic [1:0] cfg_self_update_guard, ext_cmd;
  logic [14:0] ext_addr, flash_addr, er_a;
  logic [13:0] ext_wdata, ext_rdata, flash_wdata, flash_rdata;
  logic [14:0] wr_a [64];
  logic [13:0] wr_d [64];
  int num_errors, n_tests, nop_n, st_n, er_n, bk_n, wr_n;

  pfsw_ctrl #(.OP_CYCLES(OPC)) dut (.clk, .sys_rst, .pwr_on_rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .core_force_nop,
    .core_stall, .cfg_code_lock, .cfg_self_update_guard, .ext_req, .ext_cmd, .ext_addr,
    .ext_wdata, .ext_ack, .ext_denied, .ext_rdata, .flash_addr, .flash_wdata, .flash_rd,
    .flash_wr, .flash_row_erase, .flash_bulk_erase, .flash_user_id, .flash_rdata);

  always #20 clk = ~clk;
  // Flash answers during the strobe cycle, so data is settled at the next edge
  assign flash_rdata = flash_addr[13:0] ^ 14'h2A5A;
  always @(posedge clk) begin
    nop_n += int'(core_force_nop === 1'b1);
    st_n += int'(core_stall === 1'b1);
    bk_n += int'(flash_bulk_erase === 1'b1);
    if (flash_row_erase === 1'b1) begin
      er_n++;
      er_a = flash_addr;
    end
    if (flash_wr === 1'b1 && wr_n < 64) begin
      wr_a[wr_n] = flash_addr;
      wr_d[wr_n] = flash_wdata;
      wr_n++;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    chk("wb_ack", {31'h0, wb_ack_o}, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, q, e);
  endtask
  task automatic unlock(input logic [7:0] ctl);
    wb(1'b1, pfsw_pkg::OFS_KEY, 8'h55);
    wb(1'b1, pfsw_pkg::OFS_KEY, 8'hAA);
    wb(1'b1, pfsw_pkg::OFS_CTL, ctl);
    repeat (4) @(posedge clk);
    for (int n = 0; n < 200 && core_stall === 1'b1; n++) @(posedge clk);
  endtask
  task automatic set_ptr_data(input logic [7:0] lo, input logic [13:0] d);
    wb(1'b1, pfsw_pkg::OFS_PTR_LO, lo);
    wb(1'b1, pfsw_pkg::OFS_DATA_LO, d[7:0]);
    wb(1'b1, pfsw_pkg::OFS_DATA_HI, {2'b00, d[13:8]});
  endtask
  task automatic ext(input logic [1:0] c, input logic [14:0] a);
    int n;
    n = 0;
    ext_req <= 1'b1;
    ext_cmd <= c;
    ext_addr <= a;
    ext_wdata <= 14'h0155;
    do begin
      @(posedge clk);
      n++;
    end while (ext_ack !== 1'b1 && ext_denied !== 1'b1 && n < 20);
    ok = ext_ack;
    ext_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rst(input logic lk, input logic [1:0] g);
    cfg_code_lock <= lk;
    cfg_self_update_guard <= g;
    sys_rst <= 1'b1;
    pwr_on_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    pwr_on_rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic t_regs();
    rst(1'b0, pfsw_pkg::GUARD_NONE);
    rd("ctl", pfsw_pkg::OFS_CTL, 32'h0);
    rd("key", pfsw_pkg::OFS_KEY, 32'h0);
    rd("cfg", pfsw_pkg::OFS_CFG, 32'h6);
    rd("unmapped", 8'h1C, 32'h0);
    wb(1'b1, pfsw_pkg::OFS_DATA_HI, 8'hFF);
    rd("data_hi", pfsw_pkg::OFS_DATA_HI, 32'h3F);
    wb(1'b1, pfsw_pkg::OFS_PTR_HI, 8'hFF);
    rd("ptr_hi", pfsw_pkg::OFS_PTR_HI, 32'h7F);
    wb(1'b1, pfsw_pkg::OFS_PTR_HI, 8'h00);
    wb(1'b1, pfsw_pkg::OFS_CTL, 8'h40);
    chk("user_id_target", {31'h0, flash_user_id}, 32'h1);
    wb(1'b1, pfsw_pkg::OFS_CTL, 8'h00);
    chk("user_id_clear", {31'h0, flash_user_id}, 32'h0);
    ext(pfsw_pkg::EXT_READ, 15'h0040);
    chk("locked_read", {31'h0, ok}, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_load();
    wb(1'b1, pfsw_pkg::OFS_CTL, 8'h04);
    nop_n = 0;
    st_n = 0;
    set_ptr_data(8'h40, 14'h1234);
    unlock(8'h26);
    set_ptr_data(8'h41, 14'h0ABC);
    unlock(8'h26);
    chk("load_nops", nop_n, 4);
    chk("load_stall", st_n, 0);
    rd("ctl_wr_clear", pfsw_pkg::OFS_CTL, 32'h24);
    wb(1'b1, pfsw_pkg::OFS_KEY, 8'h55);
    rd("data_lo", pfsw_pkg::OFS_DATA_LO, 32'hBC);
    wb(1'b1, pfsw_pkg::OFS_KEY, 8'hAA);
    wb(1'b1, pfsw_pkg::OFS_CTL, 8'h26);
    wb(1'b1, pfsw_pkg::OFS_CTL, 8'h00);
    unlock(8'h22);
    chk("refused_nops", nop_n, 4);
    $display("test load done");
  endtask
  task automatic t_prog_erase();
    wb(1'b1, pfsw_pkg::OFS_CTL, 8'h04);
    set_ptr_data(8'h40, 14'h1234);
    wr_n = 0;
    unlock(8'h06);
    chk("prog_writes", wr_n, 32);
    for (int i = 0; i < 32; i++) begin
      chk("prog_addr", wr_a[i], 15'h0040 + 15'(i));
      chk("prog_data", wr_d[i], i == 0 ? 14'h1234 : i == 1 ? 14'h0ABC : 14'h3FFF);
    end
    set_ptr_data(8'h45, 14'h0000);
    st_n = 0;
    er_n = 0;
    unlock(8'h16);
    chk("erase_count", er_n, 1);
    chk("erase_row", er_a, 15'h0040);
    chk("erase_stall", st_n, OPC);
    rd("ctl_erase_done", pfsw_pkg::OFS_CTL, 32'h14);
    wb(1'b1, pfsw_pkg::OFS_PTR_HI, 8'h12);
    wb(1'b1, pfsw_pkg::OFS_PTR_LO, 8'h34);
    wb(1'b1, pfsw_pkg::OFS_CTL, 8'h05);
    repeat (3) @(posedge clk);
    rd("read_lo", pfsw_pkg::OFS_DATA_LO, 32'h6E);
    rd("read_hi", pfsw_pkg::OFS_DATA_HI, 32'h38);
    rd("ctl_rd_clear", pfsw_pkg::OFS_CTL, 32'h04);
    $display("test program erase read done");
  endtask
  task automatic t_abort_guard();
    wb(1'b1, pfsw_pkg::OFS_KEY, 8'h55);
    wb(1'b1, pfsw_pkg::OFS_KEY, 8'hAA);
    wb(1'b1, pfsw_pkg::OFS_CTL, 8'h16);
    repeat (6) @(posedge clk);
    // Device reset only, so the aborted flag must survive
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, pfsw_pkg::OFS_CTL, 8'h00);
    chk("aborted", q & 32'h8, 32'h8);
    rst(1'b1, pfsw_pkg::GUARD_ALL);
    rd("ctl_por", pfsw_pkg::OFS_CTL, 32'h0);
    wb(1'b1, pfsw_pkg::OFS_CTL, 8'h04);
    set_ptr_data(8'h40, 14'h0000);
    nop_n = 0;
    er_n = 0;
    unlock(8'h16);
    chk("guard_nops", nop_n + er_n, 0);
    wr_n = 0;
    ext(pfsw_pkg::EXT_WRITE, 15'h0040);
    chk("ext_write", {31'h0, ok} + wr_n, 32'h2);
    rst(1'b0, pfsw_pkg::GUARD_NONE);
    bk_n = 0;
    ext(pfsw_pkg::EXT_BULK, 15'h0000);
    chk("bulk", {31'h0, ok} + bk_n, 32'h2);
    rd("cfg_bulk", pfsw_pkg::OFS_CFG, 32'h7);
    ext(pfsw_pkg::EXT_READ, 15'h0040);
    chk("read_after_bulk", {31'h0, ok}, 32'h1);
    chk("ext_rdata", {18'h0, ext_rdata}, 32'h2A1A);
    $display("test abort guard bulk done");
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    pwr_on_rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, ext_req, cfg_code_lock} = 5'h00;
    {wb_adr_i, wb_dat_i, ext_cmd, ext_addr, ext_wdata} = '0;
    wb_sel_i = 4'hF;
    cfg_self_update_guard = 2'h3;
    {num_errors, n_tests, nop_n, st_n, er_n, bk_n, wr_n} = '0;
    t_regs();
    t_load();
    t_prog_erase();
    t_abort_guard();
    end_sim();
  end
  // About 330 cycles expected; the 10000-cycle limit allows many times that
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
endmodule
